//--- hw/gcr_consts.vh
`ifndef GCR_CONSTS_VH
`define GCR_CONSTS_VH

// timing
`define GCR_CLK_MHZ          100
`define GCR_BLOCK_TIME_US    500
// lockout length in clock cycles: 500 us of the 100 MHz clock
`define GCR_BLOCK_CYCLES     16'hc350

// configuration port keys and layout
`define GCR_KEY_ENTER        8'h55
`define GCR_KEY_EXIT         8'haa
`define GCR_DATA_PORT_STEP   16'h0001
`define GCR_LDN_FLOPPY       8'h00
`define GCR_SOFT_RESET_BIT   0

// global register indices
`define GCR_IDX_CFG_CTRL     8'h02
`define GCR_IDX_INDEX_ADDR   8'h03
`define GCR_IDX_LDN          8'h07
`define GCR_IDX_DEV_ID       8'h20
`define GCR_IDX_REVISION     8'h21
`define GCR_IDX_PWR_CTRL     8'h22
`define GCR_IDX_PWR_MGMT     8'h23
`define GCR_IDX_OSC          8'h24
`define GCR_IDX_PORT_LOW     8'h26
`define GCR_IDX_PORT_HIGH    8'h27
`define GCR_IDX_CHECK_D      8'h2b
`define GCR_IDX_CHECK_E      8'h2c
`define GCR_IDX_CHECK_A      8'h2d
`define GCR_IDX_CHECK_B      8'h2e
`define GCR_IDX_CHECK_C      8'h2f

// floppy logical device indices
`define GCR_IDX_FD_ACT       8'h30
`define GCR_IDX_FD_BASE_HI   8'h60
`define GCR_IDX_FD_BASE_LO   8'h61
`define GCR_IDX_FD_IRQ       8'h70
`define GCR_IDX_FD_DMA       8'h74
`define GCR_IDX_FD_MODE      8'hf0
`define GCR_IDX_FD_OPTION    8'hf1
`define GCR_IDX_FD_TYPE      8'hf2
`define GCR_IDX_FD_DRV0      8'hf4
`define GCR_IDX_FD_DRV1      8'hf5

// reset values
`define GCR_RST_CFG_CTRL     8'h00
`define GCR_RST_INDEX_ADDR   8'h03
`define GCR_RST_LDN          8'h00
`define GCR_RST_PWR_CTRL     8'h00
`define GCR_RST_PWR_MGMT     8'h00
`define GCR_RST_OSC          8'h04
`define GCR_RST_PORT_LOW_S0  8'hf0
`define GCR_RST_PORT_LOW_S1  8'h70
`define GCR_RST_PORT_HIGH    8'h03
`define GCR_RST_CHECK        8'h00
`define GCR_RST_FD_ACT       8'h00
`define GCR_RST_FD_BASE_HI   8'h03
`define GCR_RST_FD_BASE_LO   8'hf0
`define GCR_RST_FD_IRQ       8'h06
`define GCR_RST_FD_DMA       8'h02
`define GCR_RST_FD_MODE      8'h0e
`define GCR_RST_FD_OPTION    8'h00
`define GCR_RST_FD_TYPE      8'hff
`define GCR_RST_FD_DRV       8'h00

`endif

//--- hw/gcr_config_bank.v
`timescale 1ns/10ps
`include "gcr_consts.vh"

module gcr_config_bank #(
	parameter [7:0]  DEVICE_CODE  = 8'h5a,   // arbitrary neutral value
	parameter [7:0]  REVISION     = 8'h01,   // arbitrary neutral value
	parameter        CNT_W        = 16,
	parameter [15:0] BLOCK_CYCLES = `GCR_BLOCK_CYCLES
) (
	// clock and reset
	input  wire        REF_CLK,
	input  wire        RST_N,
	// reset sources and strap, asynchronous pins
	input  wire        HOST_BUS_HARD_RESET,
	input  wire        MAIN_SUPPLY_POWER_ON_RESET,
	input  wire        STANDBY_SUPPLY_POWER_ON_RESET,
	input  wire        STRAP_CFG_SEL,
	// host bus
	input  wire [15:0] SA,
	input  wire        AEN,
	input  wire        IOR_N,
	input  wire        IOW_N,
	input  wire [7:0]  SD_IN,
	output reg  [7:0]  SD_OUT,
	output reg         SD_OE,
	// state seen by the rest of the chip
	output reg         CFG_MODE,
	output wire        HOST_BLOCKED,
	output wire [15:0] CFG_PORT_BASE,
	output wire [15:0] FLOPPY_BASE,
	output wire [7:0]  FLOPPY_ACTIVATE,
	output wire [7:0]  FLOPPY_IRQ_SEL,
	output wire [7:0]  FLOPPY_DMA_SEL
);

	// two-stage synchronisers; stage one is read only by stage two
	reg  [3:0]  rst_s1;
	reg  [3:0]  rst_s2;
	reg         strap_s1;
	reg         strap_s2;
	reg  [15:0] sa_s1;
	reg  [15:0] sa_s2;
	reg         aen_s1;
	reg         aen_s2;
	reg         ior_s1;
	reg         ior_s2;
	reg         iow_s1;
	reg         iow_s2;
	reg         iow_d;
	reg  [7:0]  sd_s1;
	reg  [7:0]  sd_s2;

	// register file
	reg  [7:0]  index;
	reg  [7:0]  cfg_ctrl;
	reg  [7:0]  index_addr;
	reg  [7:0]  ldn;
	reg  [7:0]  pwr_ctrl;
	reg  [7:0]  pwr_mgmt;
	reg  [7:0]  osc_ctrl;
	reg  [7:0]  port_low;
	reg  [7:0]  port_high;
	reg  [7:0]  check_a;
	reg  [7:0]  check_b;
	reg  [7:0]  check_c;
	reg  [7:0]  check_d;
	reg  [7:0]  check_e;
	reg  [7:0]  fd_act;
	reg  [7:0]  fd_base_hi;
	reg  [7:0]  fd_base_lo;
	reg  [7:0]  fd_irq;
	reg  [7:0]  fd_dma;
	reg  [7:0]  fd_mode;
	reg  [7:0]  fd_option;
	reg  [7:0]  fd_type;
	reg  [7:0]  fd_drv0;
	reg  [7:0]  fd_drv1;

	reg             soft_reset;
	reg  [CNT_W-1:0] block_cnt;
	reg  [7:0]      next_rd_data;

	wire        hard_rst;
	wire        main_rst;
	wire        stby_rst;
	wire        rst_all;
	wire        rst_nosoft;
	wire        rst_hm;
	wire        rst_ms;
	wire [15:0] port_base;
	wire        hit_index;
	wire        hit_data;
	wire        wr_strobe;
	wire        wr_index;
	wire        wr_data;
	wire        rd_active;
	wire        floppy_sel;
	wire        global_idx;

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			rst_s1   <= 4'h0;
			rst_s2   <= 4'h0;
			strap_s1 <= STRAP_CFG_SEL;
			strap_s2 <= strap_s1;
			sa_s1    <= 16'h0000;
			sa_s2    <= 16'h0000;
			aen_s1   <= 1'b1;
			aen_s2   <= 1'b1;
			ior_s1   <= 1'b1;
			ior_s2   <= 1'b1;
			iow_s1   <= 1'b1;
			iow_s2   <= 1'b1;
			iow_d    <= 1'b1;
			sd_s1    <= 8'h00;
			sd_s2    <= 8'h00;
		end else begin
			rst_s1   <= {1'b0, STANDBY_SUPPLY_POWER_ON_RESET, MAIN_SUPPLY_POWER_ON_RESET, HOST_BUS_HARD_RESET};
			rst_s2   <= rst_s1;
			strap_s1 <= STRAP_CFG_SEL;
			strap_s2 <= strap_s1;
			sa_s1    <= SA;
			sa_s2    <= sa_s1;
			aen_s1   <= AEN;
			aen_s2   <= aen_s1;
			ior_s1   <= IOR_N;
			ior_s2   <= ior_s1;
			iow_s1   <= IOW_N;
			iow_s2   <= iow_s1;
			iow_d    <= iow_s2;
			sd_s1    <= SD_IN;
			sd_s2    <= sd_s1;
		end
	end

	assign hard_rst   = rst_s2[0];
	assign main_rst   = rst_s2[1];
	assign stby_rst   = rst_s2[2];
	// reset classes by which sources reload a register
	assign rst_all    = hard_rst | main_rst | stby_rst | soft_reset;
	assign rst_nosoft = hard_rst | main_rst | stby_rst;
	assign rst_hm     = hard_rst | main_rst;
	assign rst_ms     = main_rst | stby_rst;

	// host lockout after main power-on; RST_N is the first power-up
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			block_cnt <= BLOCK_CYCLES[CNT_W-1:0];
		end else if (main_rst) begin
			block_cnt <= BLOCK_CYCLES[CNT_W-1:0];
		end else if (block_cnt != {CNT_W{1'b0}}) begin
			block_cnt <= block_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
	assign HOST_BLOCKED = (block_cnt != {CNT_W{1'b0}});

	assign port_base  = {port_high, port_low};
	assign hit_index  = !aen_s2 && (sa_s2 == port_base);
	assign hit_data   = !aen_s2 && (sa_s2 == port_base + `GCR_DATA_PORT_STEP);
	// write is taken on the trailing edge of the strobe, when data is settled
	assign wr_strobe  = iow_s2 && !iow_d && !HOST_BLOCKED;
	assign wr_index   = wr_strobe && hit_index;
	assign wr_data    = wr_strobe && hit_data && CFG_MODE;
	assign rd_active  = !ior_s2 && CFG_MODE && (hit_index || hit_data) && !HOST_BLOCKED;
	assign global_idx = (index < `GCR_IDX_FD_ACT);
	assign floppy_sel = (ldn == `GCR_LDN_FLOPPY) && !global_idx;

	// configuration state and index pointer
	always @(posedge REF_CLK) begin
		if (!RST_N || rst_hm) begin
			CFG_MODE <= 1'b0;
			index    <= 8'h00;
		end else if (wr_index) begin
			if (!CFG_MODE) begin
				if (sd_s2 == `GCR_KEY_ENTER)
					CFG_MODE <= 1'b1;
			end else if (sd_s2 == `GCR_KEY_EXIT) begin
				CFG_MODE <= 1'b0;
			end else begin
				index <= sd_s2;
			end
		end
	end

	// soft reset pulse; the control bit itself does not stay set
	always @(posedge REF_CLK) begin
		if (!RST_N)
			soft_reset <= 1'b0;
		else
			soft_reset <= wr_data && (index == `GCR_IDX_CFG_CTRL) && sd_s2[`GCR_SOFT_RESET_BIT];
	end

	// global registers; each reset class reloads only its own members
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			cfg_ctrl   <= `GCR_RST_CFG_CTRL;
			index_addr <= `GCR_RST_INDEX_ADDR;
			ldn        <= `GCR_RST_LDN;
			pwr_ctrl   <= `GCR_RST_PWR_CTRL;
			pwr_mgmt   <= `GCR_RST_PWR_MGMT;
			osc_ctrl   <= `GCR_RST_OSC;
			port_low   <= strap_s2 ? `GCR_RST_PORT_LOW_S1 : `GCR_RST_PORT_LOW_S0;
			port_high  <= `GCR_RST_PORT_HIGH;
			check_a    <= `GCR_RST_CHECK;
			check_b    <= `GCR_RST_CHECK;
			check_c    <= `GCR_RST_CHECK;
			check_d    <= `GCR_RST_CHECK;
			check_e    <= `GCR_RST_CHECK;
		end else begin
			if (wr_data && !floppy_sel && global_idx) begin
				case (index)
				`GCR_IDX_CFG_CTRL: cfg_ctrl <= sd_s2 & ~(8'h01 << `GCR_SOFT_RESET_BIT);
				`GCR_IDX_INDEX_ADDR: index_addr <= sd_s2;
				`GCR_IDX_LDN: ldn <= sd_s2;
				`GCR_IDX_PWR_CTRL: pwr_ctrl <= sd_s2;
				`GCR_IDX_PWR_MGMT: pwr_mgmt <= sd_s2;
				`GCR_IDX_OSC: osc_ctrl <= sd_s2;
				`GCR_IDX_PORT_LOW: port_low <= sd_s2;
				`GCR_IDX_PORT_HIGH: port_high <= sd_s2;
				`GCR_IDX_CHECK_A: check_a <= sd_s2;
				`GCR_IDX_CHECK_B: check_b <= sd_s2;
				`GCR_IDX_CHECK_C: check_c <= sd_s2;
				`GCR_IDX_CHECK_D: check_d <= sd_s2;
				`GCR_IDX_CHECK_E: check_e <= sd_s2;
				default: cfg_ctrl <= cfg_ctrl;
				endcase
			end
			if (rst_all) begin
				ldn      <= `GCR_RST_LDN;
				pwr_ctrl <= `GCR_RST_PWR_CTRL;
			end
			if (rst_nosoft) begin
				cfg_ctrl   <= `GCR_RST_CFG_CTRL;
				index_addr <= `GCR_RST_INDEX_ADDR;
				pwr_mgmt   <= `GCR_RST_PWR_MGMT;
				osc_ctrl   <= `GCR_RST_OSC;
			end
			// strap is read live while the reset is held, so its level at release sticks
			if (rst_hm) begin
				port_low  <= strap_s2 ? `GCR_RST_PORT_LOW_S1 : `GCR_RST_PORT_LOW_S0;
				port_high <= `GCR_RST_PORT_HIGH;
			end
			if (rst_ms) begin
				check_a <= `GCR_RST_CHECK;
				check_b <= `GCR_RST_CHECK;
				check_c <= `GCR_RST_CHECK;
				check_d <= `GCR_RST_CHECK;
				check_e <= `GCR_RST_CHECK;
			end
		end
	end

	// floppy logical device registers
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			fd_act     <= `GCR_RST_FD_ACT;
			fd_base_hi <= `GCR_RST_FD_BASE_HI;
			fd_base_lo <= `GCR_RST_FD_BASE_LO;
			fd_irq     <= `GCR_RST_FD_IRQ;
			fd_dma     <= `GCR_RST_FD_DMA;
			fd_mode    <= `GCR_RST_FD_MODE;
			fd_option  <= `GCR_RST_FD_OPTION;
			fd_type    <= `GCR_RST_FD_TYPE;
			fd_drv0    <= `GCR_RST_FD_DRV;
			fd_drv1    <= `GCR_RST_FD_DRV;
		end else begin
			if (wr_data && floppy_sel) begin
				case (index)
				`GCR_IDX_FD_ACT: fd_act <= sd_s2;
				`GCR_IDX_FD_BASE_HI: fd_base_hi <= sd_s2;
				`GCR_IDX_FD_BASE_LO: fd_base_lo <= sd_s2;
				`GCR_IDX_FD_IRQ: fd_irq <= sd_s2;
				`GCR_IDX_FD_DMA: fd_dma <= sd_s2;
				`GCR_IDX_FD_MODE: fd_mode <= sd_s2;
				`GCR_IDX_FD_OPTION: fd_option <= sd_s2;
				`GCR_IDX_FD_TYPE: fd_type <= sd_s2;
				`GCR_IDX_FD_DRV0: fd_drv0 <= sd_s2;
				`GCR_IDX_FD_DRV1: fd_drv1 <= sd_s2;
				default: fd_act <= fd_act;
				endcase
			end
			if (rst_all) begin
				fd_act     <= `GCR_RST_FD_ACT;
				fd_base_hi <= `GCR_RST_FD_BASE_HI;
				fd_base_lo <= `GCR_RST_FD_BASE_LO;
				fd_irq     <= `GCR_RST_FD_IRQ;
				fd_dma     <= `GCR_RST_FD_DMA;
			end
			if (rst_nosoft) begin
				fd_mode   <= `GCR_RST_FD_MODE;
				fd_option <= `GCR_RST_FD_OPTION;
				fd_type   <= `GCR_RST_FD_TYPE;
				fd_drv0   <= `GCR_RST_FD_DRV;
				fd_drv1   <= `GCR_RST_FD_DRV;
			end
		end
	end

	// read mux; write-only control and unmapped indices read zero
	always @* begin
		next_rd_data = 8'h00;
		if (hit_index) begin
			next_rd_data = index;
		end else if (floppy_sel) begin
			case (index)
			`GCR_IDX_FD_ACT: next_rd_data = fd_act;
			`GCR_IDX_FD_BASE_HI: next_rd_data = fd_base_hi;
			`GCR_IDX_FD_BASE_LO: next_rd_data = fd_base_lo;
			`GCR_IDX_FD_IRQ: next_rd_data = fd_irq;
			`GCR_IDX_FD_DMA: next_rd_data = fd_dma;
			`GCR_IDX_FD_MODE: next_rd_data = fd_mode;
			`GCR_IDX_FD_OPTION: next_rd_data = fd_option;
			`GCR_IDX_FD_TYPE: next_rd_data = fd_type;
			`GCR_IDX_FD_DRV0: next_rd_data = fd_drv0;
			`GCR_IDX_FD_DRV1: next_rd_data = fd_drv1;
			default: next_rd_data = 8'h00;
			endcase
		end else if (global_idx) begin
			case (index)
			`GCR_IDX_INDEX_ADDR: next_rd_data = index_addr;
			`GCR_IDX_LDN: next_rd_data = ldn;
			`GCR_IDX_DEV_ID: next_rd_data = DEVICE_CODE;
			`GCR_IDX_REVISION: next_rd_data = REVISION;
			`GCR_IDX_PWR_CTRL: next_rd_data = pwr_ctrl;
			`GCR_IDX_PWR_MGMT: next_rd_data = pwr_mgmt;
			`GCR_IDX_OSC: next_rd_data = osc_ctrl;
			`GCR_IDX_PORT_LOW: next_rd_data = port_low;
			`GCR_IDX_PORT_HIGH: next_rd_data = port_high;
			`GCR_IDX_CHECK_A: next_rd_data = check_a;
			`GCR_IDX_CHECK_B: next_rd_data = check_b;
			`GCR_IDX_CHECK_C: next_rd_data = check_c;
			`GCR_IDX_CHECK_D: next_rd_data = check_d;
			`GCR_IDX_CHECK_E: next_rd_data = check_e;
			default: next_rd_data = 8'h00;
			endcase
		end
	end

	// data bus driven from flops; costs a cycle but keeps glitches off the pins
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			SD_OUT <= 8'h00;
			SD_OE  <= 1'b0;
		end else begin
			SD_OUT <= next_rd_data;
			SD_OE  <= rd_active;
		end
	end

	assign CFG_PORT_BASE   = port_base;
	assign FLOPPY_BASE     = {fd_base_hi, fd_base_lo};
	assign FLOPPY_ACTIVATE = fd_act;
	assign FLOPPY_IRQ_SEL  = fd_irq;
	assign FLOPPY_DMA_SEL  = fd_dma;

endmodule

//--- test/gcr_config_bank_monitor.sv
`timescale 1ns/10ps
module gcr_mon (
	// clock and resets
	input wire        REF_CLK,
	input wire        RST_N,
	input wire        HOST_BUS_HARD_RESET,
	input wire        MAIN_SUPPLY_POWER_ON_RESET,
	input wire        STANDBY_SUPPLY_POWER_ON_RESET,
	input wire        STRAP_CFG_SEL,
	// host bus
	input wire [15:0] SA,
	input wire        AEN,
	input wire        IOR_N,
	input wire        SD_OE,
	// state
	input wire        CFG_MODE,
	input wire        HOST_BLOCKED,
	input wire [15:0] CFG_PORT_BASE,
	input wire [15:0] FLOPPY_BASE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	AST_BLOCK_SET: assert property (MAIN_SUPPLY_POWER_ON_RESET[*4] |=> HOST_BLOCKED)
		else $error("lockout not raised");
	AST_BLOCK_QUIET: assert property (HOST_BLOCKED[*6] |-> !SD_OE)
		else $error("answer while locked");
	AST_PORT_S0: assert property ((HOST_BUS_HARD_RESET && !STRAP_CFG_SEL)[*5] |=> CFG_PORT_BASE == 16'h03f0)
		else $error("port base strap low");
	AST_PORT_S1: assert property ((HOST_BUS_HARD_RESET && STRAP_CFG_SEL)[*5] |=> CFG_PORT_BASE == 16'h0370)
		else $error("port base strap high");
	AST_FD_BASE: assert property (STANDBY_SUPPLY_POWER_ON_RESET[*5] |=> FLOPPY_BASE == 16'h03f0)
		else $error("floppy base not reloaded");
	AST_PORT_KEEP: assert property (STANDBY_SUPPLY_POWER_ON_RESET[*4] |=> $stable(CFG_PORT_BASE))
		else $error("port base touched");
	AST_READ_LAT: assert property ($fell(IOR_N) && !AEN && CFG_MODE && !HOST_BLOCKED
		&& SA == CFG_PORT_BASE + 16'h0001 |-> ##[3:5] SD_OE)
		else $error("data read unanswered");
	AST_RUN_QUIET: assert property ((!CFG_MODE)[*6] |-> !SD_OE)
		else $error("answer in run mode");
	AST_OE_DROP: assert property (IOR_N[*6] |-> !SD_OE)
		else $error("drive held after read");
	cover property ($rose(SD_OE));
	cover property (HOST_BUS_HARD_RESET && STRAP_CFG_SEL);
	cover property ($fell(HOST_BLOCKED));
endmodule
bind gcr_config_bank gcr_mon mon (.*);

//--- test/gcr_host_model.sv
`timescale 1ns/10ps
module gcr_host (
	// clock
	input wire        clk,
	// bus to the device
	output reg [15:0] sa,
	output reg        aen,
	output reg        ior_n,
	output reg        iow_n,
	output reg [7:0]  sd_in,
	input wire [7:0]  sd_out,
	input wire        sd_oe
);
	integer i;
	initial begin
		{sa, aen, ior_n, iow_n, sd_in} = {16'h0000, 1'b0, 1'b1, 1'b1, 8'h00};
	end
	// released lines show the inverse so a stale value never looks valid
	task wr(input [15:0] a, input [7:0] v);
		begin
			@(posedge clk);
			{sa, sd_in, iow_n} <= {a, v, 1'b0};
			repeat (5) @(posedge clk);
			iow_n <= 1'b1;
			repeat (5) @(posedge clk);
			{sa, sd_in} <= {~a, ~v};
			repeat (4) @(posedge clk);
		end
	endtask
	task rd(input [15:0] a, output ok, output [7:0] v);
		begin
			{ok, v} = 9'h000;
			@(posedge clk);
			{sa, ior_n} <= {a, 1'b0};
			for (i = 0; i < 10 && !ok; i = i + 1) begin
				@(posedge clk);
				if (sd_oe === 1'b1)
					{ok, v} = {1'b1, sd_out};
			end
			ior_n <= 1'b1;
			repeat (6) @(posedge clk);
			sa <= ~a;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule

//--- test/gcr_config_bank_bench.sv
`timescale 1ns/10ps
module gcr_config_bank_bench;
	reg         REF_CLK, RST_N, HOST_BUS_HARD_RESET, MAIN_SUPPLY_POWER_ON_RESET;
	reg         STANDBY_SUPPLY_POWER_ON_RESET, STRAP_CFG_SEL;
	wire [15:0] SA, CFG_PORT_BASE, FLOPPY_BASE;
	wire        AEN, IOR_N, IOW_N, SD_OE, CFG_MODE, HOST_BLOCKED;
	wire [7:0]  SD_IN, SD_OUT, FLOPPY_ACTIVATE, FLOPPY_IRQ_SEL, FLOPPY_DMA_SEL;
	integer     errors, cmp_count;
	reg [15:0]  base;
	reg         ok;
	reg [7:0]   d;
	// identification values are arbitrary
	localparam [7:0] ID = 8'h5a, REV = 8'h01;
	gcr_config_bank #(.DEVICE_CODE(ID), .REVISION(REV), .BLOCK_CYCLES(16'd20)) uut (.*);
	gcr_host host (.clk(REF_CLK), .sa(SA), .aen(AEN), .ior_n(IOR_N), .iow_n(IOW_N),
		.sd_in(SD_IN), .sd_out(SD_OUT), .sd_oe(SD_OE));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task wreg(input [7:0] i, input [7:0] v);
		begin
			host.wr(base, i);
			host.wr(base + 16'h0001, v);
		end
	endtask
	task rreg(input [7:0] i, input [7:0] e);
		begin
			host.wr(base, i);
			host.rd(base + 16'h0001, ok, d);
			chk({7'h00, ok, d}, {8'h01, e});
		end
	endtask
	task pulse(input [2:0] m, input s);
		begin
			@(posedge REF_CLK);
			{MAIN_SUPPLY_POWER_ON_RESET, STANDBY_SUPPLY_POWER_ON_RESET, HOST_BUS_HARD_RESET} <= m;
			STRAP_CFG_SEL <= s;
			repeat (6) @(posedge REF_CLK);
			{MAIN_SUPPLY_POWER_ON_RESET, STANDBY_SUPPLY_POWER_ON_RESET, HOST_BUS_HARD_RESET} <= 3'b000;
			repeat (6) @(posedge REF_CLK);
		end
	endtask
	// the host holds off until the lockout ends, so the wait is bounded
	task wait_free;
		integer n;
		begin
			for (n = 0; HOST_BLOCKED !== 1'b0 && n <= 100; n = n + 1)
				@(posedge REF_CLK);
			if (HOST_BLOCKED !== 1'b0) begin
				errors = errors + 1;
				finish_test;
			end
		end
	endtask
	task t_lockout;
		begin
			host.wr(base, 8'h55);
			chk(HOST_BLOCKED, 16'h0001);
			wait_free;
			chk(CFG_MODE, 16'h0000);
			// a key sent during a dma cycle must not count as a port access
			host.aen <= 1'b1;
			host.wr(base, 8'h55);
			host.aen <= 1'b0;
			chk(CFG_MODE, 16'h0000);
			$display("lockout done");
		end
	endtask
	task t_ids;
		begin
			host.wr(base, 8'h55);
			chk(CFG_MODE, 16'h0001);
			wreg(8'h20, 8'hff);
			wreg(8'h21, 8'hfe);
			rreg(8'h20, ID);
			rreg(8'h21, REV);
			rreg(8'h26, 8'hf0);
			rreg(8'h27, 8'h03);
			rreg(8'h02, 8'h00);
			rreg(8'h60, 8'h03);
			rreg(8'h61, 8'hf0);
			host.rd(base, ok, d);
			chk({7'h00, ok, d}, 16'h0161);
			$display("ids done");
		end
	endtask
	task t_soft;
		begin
			wreg(8'h60, 8'h12);
			wreg(8'h61, 8'h34);
			chk(FLOPPY_BASE, 16'h1234);
			wreg(8'h22, 8'h5a);
			wreg(8'h23, 8'ha5);
			wreg(8'h30, 8'h01);
			wreg(8'h70, 8'h0b);
			wreg(8'h74, 8'h01);
			wreg(8'h02, 8'h01);
			chk({FLOPPY_ACTIVATE, FLOPPY_IRQ_SEL}, 16'h0006);
			chk(FLOPPY_BASE, 16'h03f0);
			chk({8'h00, FLOPPY_DMA_SEL}, 16'h0002);
			rreg(8'h22, 8'h00);
			rreg(8'h23, 8'ha5);
			chk(CFG_MODE, 16'h0001);
			$display("soft done");
		end
	endtask
	task t_ldn;
		begin
			wreg(8'h07, 8'h01);
			wreg(8'h60, 8'h55);
			rreg(8'h60, 8'h00);
			rreg(8'h21, REV);
			wreg(8'h07, 8'h00);
			rreg(8'h60, 8'h03);
			$display("ldn done");
		end
	endtask
	task t_standby;
		begin
			wreg(8'h26, 8'h70);
			base = 16'h0370;
			chk(CFG_PORT_BASE, base);
			wreg(8'h2b, 8'h11);
			wreg(8'h60, 8'h12);
			pulse(3'b010, 1'b0);
			chk(FLOPPY_BASE, 16'h03f0);
			chk(CFG_PORT_BASE, base);
			rreg(8'h2b, 8'h00);
			rreg(8'h23, 8'h00);
			$display("standby done");
		end
	endtask
	task t_hard;
		begin
			wreg(8'h2c, 8'h22);
			wreg(8'h27, 8'h02);
			base = 16'h0270;
			pulse(3'b001, 1'b1);
			chk(CFG_PORT_BASE, 16'h0370);
			chk(CFG_MODE, 16'h0000);
			base = 16'h0370;
			host.wr(base, 8'h55);
			rreg(8'h2c, 8'h22);
			pulse(3'b001, 1'b0);
			chk(CFG_PORT_BASE, 16'h03f0);
			base = 16'h03f0;
			$display("hard done");
		end
	endtask
	task t_main;
		begin
			host.wr(base, 8'h55);
			wreg(8'h2c, 8'h33);
			wreg(8'h22, 8'h5a);
			pulse(3'b100, 1'b0);
			chk(HOST_BLOCKED, 16'h0001);
			wait_free;
			host.wr(base, 8'h55);
			rreg(8'h2c, 8'h00);
			rreg(8'h22, 8'h00);
			rreg(8'h26, 8'hf0);
			host.wr(base, 8'haa);
			chk(CFG_MODE, 16'h0000);
			host.rd(base + 16'h0001, ok, d);
			chk(ok, 16'h0000);
			$display("main done");
		end
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	initial begin
		{errors, cmp_count, base} = {32'd0, 32'd0, 16'h03f0};
		{RST_N, HOST_BUS_HARD_RESET, MAIN_SUPPLY_POWER_ON_RESET} = 3'b000;
		{STANDBY_SUPPLY_POWER_ON_RESET, STRAP_CFG_SEL} = 2'b00;
		repeat (8) @(posedge REF_CLK);
		RST_N <= 1'b1;
		t_lockout;
		t_ids;
		t_soft;
		t_ldn;
		t_standby;
		t_hard;
		t_main;
		finish_test;
	end
endmodule
